//--- rtl/usr_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module usr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int LVL_W = $clog2(DEPTH) + 1
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	// occupancy
	output logic      [LVL_W-1:0] level
);

	localparam int PW = LVL_W - 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [LVL_W-1:0] wr_q;
	logic [LVL_W-1:0] rd_q;
	logic             push;
	logic             pop;

	assign level     = wr_q - rd_q;
	assign in_ready  = (level != LVL_W'(DEPTH));
	assign out_valid = (wr_q != rd_q);
	assign out_data  = mem[rd_q[PW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_q[PW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + LVL_W'(1);
			end
			if (pop) begin
				rd_q <= rd_q + LVL_W'(1);
			end
		end
	end

endmodule : usr_fifo

`default_nettype wire

//--- rtl/usr_pkg.sv
package usr_pkg;

	// register byte addresses on the apb slave
	localparam int          USR_AW          = 12;
	localparam logic [11:0] USR_CTRL_OFF    = 12'h000;
	localparam logic [11:0] USR_CMD_OFF     = 12'h004;
	localparam logic [11:0] USR_STATUS_OFF  = 12'h008;
	localparam logic [11:0] USR_COUNT_OFF   = 12'h00C;
	localparam logic [11:0] USR_LAST_OFF    = 12'h010;
	localparam logic [11:0] USR_PINS_OFF    = 12'h014;

	// control fields and reset value
	localparam int          USR_CTRL_SRC    = 0;
	localparam int          USR_CTRL_RUN    = 1;
	localparam logic [1:0]  USR_CTRL_RST    = 2'h0;

	// status fields
	localparam int          USR_ST_STAGE    = 0;
	localparam int          USR_ST_EMPTY    = 4;
	localparam int          USR_ST_FULL     = 5;
	localparam int          USR_ST_LOADED   = 6;
	localparam int          USR_ST_LEVEL    = 8;

	// stage count, command width and command queue depth
	localparam int          USR_STAGES      = 4;
	localparam int          USR_CMD_W       = 8;
	localparam int          USR_FIFO_DEPTH  = 16;
	localparam int          USR_LVL_W       = 5;
	localparam int          USR_CNT_W       = 8;
	localparam logic [7:0]  USR_CNT_RST     = 8'h00;
	localparam int          USR_SYNC_W      = 8;

	// select pattern {first, second}
	typedef enum logic [1:0] {
		USR_LOAD  = 2'h0,
		USR_SHR   = 2'h1,
		USR_SHL   = 2'h2,
		USR_HOLD  = 2'h3
	} usr_mode_e;

	typedef struct packed {
		logic       sel_first;
		logic       sel_second;
		logic       left_in;
		logic       right_in;
		logic [3:0] par;
	} usr_cmd_s;

endpackage : usr_pkg

//--- rtl/usr_shift_top.sv
// How it works
// - select pattern low-low loads parallel inputs into the same-index stages.
// - low-high shifts toward stage zero; stage three takes right serial input.
// - high-low shifts toward stage three; stage zero takes left serial input.
// - high-high keeps all four stages unchanged on the edge.
// - stages change only at rising clock edges, sampling selects and data there.
// - operation chosen by selects, applied only while run is set and a command is ready; the clock is never gated.
// - all four stage values drive the outputs continuously.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module usr_shift_top
	import usr_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// operation selects
	input  wire logic        op_select_first,
	input  wire logic        op_select_second,
	// serial inputs
	input  wire logic        left_serial_in,
	input  wire logic        right_serial_in,
	// parallel inputs
	input  wire logic        par_in_0,
	input  wire logic        par_in_1,
	input  wire logic        par_in_2,
	input  wire logic        par_in_3,
	// stage outputs
	output logic             stage_out_0,
	output logic             stage_out_1,
	output logic             stage_out_2,
	output logic             stage_out_3
);

	logic [1:0]            ctrl_q;
	logic [USR_STAGES-1:0] stage_q;
	logic [USR_STAGES-1:0] stage_d;
	logic                  loaded_q;
	logic [31:0]           prdata_q;
	logic                  err_q;
	usr_cmd_s              last_q;
	logic [USR_CNT_W-1:0]  cnt_q [4];

	logic [USR_SYNC_W-1:0] pins_raw;
	logic [USR_SYNC_W-1:0] pins_sync;
	usr_cmd_s              pin_cmd;
	usr_cmd_s              fifo_cmd;
	usr_cmd_s              cur_cmd;
	usr_mode_e             cur_mode;
	logic                  src_fifo;
	logic                  run;
	logic                  apply;
	logic                  fifo_in_valid;
	logic                  fifo_in_ready;
	logic                  fifo_out_valid;
	logic                  fifo_out_ready;
	logic [USR_LVL_W-1:0]  fifo_level;
	logic [USR_CMD_W-1:0]  fifo_out_data;
	logic [USR_STAGES-1:0] shr_src;
	logic [USR_STAGES-1:0] shl_src;

	logic                  setup;
	logic                  access;
	logic                  wr_ok;
	logic                  wr_ctrl;
	logic                  wr_cmd;
	logic                  wr_count;
	logic                  cmd_stall;
	logic                  cmd_full_err;
	logic                  addr_hit;
	logic [31:0]           rd_mux;

	// pin path
	assign pins_raw = {op_select_first, op_select_second, left_serial_in, right_serial_in,
		par_in_3, par_in_2, par_in_1, par_in_0};

	usr_sync #(
		.WIDTH (USR_SYNC_W)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (pins_raw),
		.sync_out (pins_sync)
	);

	assign pin_cmd = usr_cmd_s'(pins_sync);

	// command queue written by software
	usr_fifo #(
		.WIDTH (USR_CMD_W),
		.DEPTH (USR_FIFO_DEPTH),
		.LVL_W (USR_LVL_W)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (pwdata[USR_CMD_W-1:0]),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data),
		.level     (fifo_level)
	);

	assign fifo_cmd = usr_cmd_s'(fifo_out_data);

	// operation source and select decode
	assign src_fifo       = ctrl_q[USR_CTRL_SRC];
	assign run            = ctrl_q[USR_CTRL_RUN];
	assign cur_cmd        = src_fifo ? fifo_cmd : pin_cmd;
	assign cur_mode       = usr_mode_e'({cur_cmd.sel_first, cur_cmd.sel_second});
	assign apply          = run && (!src_fifo || fifo_out_valid);
	assign fifo_out_ready = run && src_fifo;

	// neighbour sources for each shift direction
	assign shr_src = {cur_cmd.right_in, stage_q[USR_STAGES-1:1]};
	assign shl_src = {stage_q[USR_STAGES-2:0], cur_cmd.left_in};

	for (genvar i = 0; i < USR_STAGES; i++) begin : g_stage
		always_comb begin
			case (cur_mode)
				USR_LOAD: stage_d[i] = cur_cmd.par[i];
				USR_SHR:  stage_d[i] = shr_src[i];
				USR_SHL:  stage_d[i] = shl_src[i];
				USR_HOLD: stage_d[i] = stage_q[i];
				default:  stage_d[i] = stage_q[i];
			endcase
		end

		// each stage takes the parallel input of its own index
		load_stage_a: assert property (@(posedge pclk) disable iff (!presetn)
			apply && cur_mode == USR_LOAD |=> stage_q[i] == $past(cur_cmd.par[i]))
			else $error("a stage missed its own parallel input");
	end

	// stages carry no reset: contents stay unknown until a load or serial entry writes them
	always_ff @(posedge pclk) begin
		if (apply) begin
			stage_q <= stage_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded_q <= 1'b0;
		end else if (apply && cur_mode == USR_LOAD) begin
			loaded_q <= 1'b1;
		end
	end

	assign stage_out_0 = stage_q[0];
	assign stage_out_1 = stage_q[1];
	assign stage_out_2 = stage_q[2];
	assign stage_out_3 = stage_q[3];

	// last command applied
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_q <= '0;
		end else if (apply) begin
			last_q <= cur_cmd;
		end
	end

	// apb decode
	assign setup        = psel && !penable;
	assign access       = psel && penable;
	assign wr_ok        = access && pwrite && pstrb[0];
	assign wr_ctrl      = wr_ok && paddr == USR_CTRL_OFF;
	assign wr_cmd       = wr_ok && paddr == USR_CMD_OFF;
	assign wr_count     = wr_ok && paddr == USR_COUNT_OFF;
	// a full queue that is draining stalls the bus; one that is not refuses
	assign cmd_stall    = wr_cmd && !fifo_in_ready && fifo_out_ready;
	assign cmd_full_err = wr_cmd && !fifo_in_ready && !fifo_out_ready;
	assign fifo_in_valid = wr_cmd && fifo_in_ready;

	assign pready  = !cmd_stall;
	assign pslverr = access && (err_q || cmd_full_err);
	assign prdata  = prdata_q;

	always_comb begin
		addr_hit = 1'b1;
		rd_mux   = 32'h0000_0000;
		case (paddr)
			USR_CTRL_OFF: begin
				rd_mux[1:0] = ctrl_q;
			end
			USR_CMD_OFF: begin
				rd_mux = 32'h0000_0000;
			end
			USR_STATUS_OFF: begin
				rd_mux[USR_ST_STAGE +: USR_STAGES] = stage_q;
				rd_mux[USR_ST_EMPTY]                = !fifo_out_valid;
				rd_mux[USR_ST_FULL]                 = !fifo_in_ready;
				rd_mux[USR_ST_LOADED]               = loaded_q;
				rd_mux[USR_ST_LEVEL +: USR_LVL_W]   = fifo_level;
			end
			USR_COUNT_OFF: begin
				rd_mux = {cnt_q[3], cnt_q[2], cnt_q[1], cnt_q[0]};
			end
			USR_LAST_OFF: begin
				rd_mux[USR_CMD_W-1:0] = last_q;
			end
			USR_PINS_OFF: begin
				rd_mux[USR_SYNC_W-1:0] = pins_sync;
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	// read data and address error are captured in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			err_q    <= 1'b0;
		end else if (setup) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
			err_q    <= !addr_hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= USR_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= pwdata[1:0];
		end
	end

	// edges applied per mode; a count in the clearing cycle survives as one
	for (genvar m = 0; m < 4; m++) begin : g_count
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_q[m] <= USR_CNT_RST;
			end else if (apply && cur_mode == usr_mode_e'(m)) begin
				cnt_q[m] <= wr_count ? USR_CNT_W'(1) : cnt_q[m] + USR_CNT_W'(1);
			end else if (wr_count) begin
				cnt_q[m] <= USR_CNT_RST;
			end
		end

		// one applied edge adds exactly one to the counter of its mode
		count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
			apply && cur_mode == usr_mode_e'(m) && !wr_count |=> cnt_q[m] == $past(cnt_q[m]) + USR_CNT_W'(1))
			else $error("mode counter did not step on an applied edge");

		count_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
			wr_count && !(apply && cur_mode == usr_mode_e'(m)) |=> cnt_q[m] == USR_CNT_RST)
			else $error("mode counter survived a clearing write");
	end

	// checks
	load_match_a: assert property (@(posedge pclk) disable iff (!presetn)
		apply && cur_mode == USR_LOAD |=> stage_q == $past(cur_cmd.par))
		else $error("parallel load did not reach the stages");

	shift_right_a: assert property (@(posedge pclk) disable iff (!presetn)
		apply && loaded_q && cur_mode == USR_SHR
		|=> stage_q == {$past(cur_cmd.right_in), $past(stage_q[3:1])})
		else $error("shift toward stage zero gave wrong stages");

	shift_left_a: assert property (@(posedge pclk) disable iff (!presetn)
		apply && loaded_q && cur_mode == USR_SHL
		|=> stage_q == {$past(stage_q[2:0]), $past(cur_cmd.left_in)})
		else $error("shift toward stage three gave wrong stages");

	hold_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		apply && loaded_q && cur_mode == USR_HOLD |=> $stable(stage_q))
		else $error("hold pattern changed a stage");

	idle_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		!apply && loaded_q |=> $stable(stage_q))
		else $error("stages changed without an applied edge");

	pin_every_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
		run && !src_fifo |-> apply ##1 (last_q == $past(pin_cmd)))
		else $error("pin operation skipped a clock edge");

	status_stage_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && paddr == USR_STATUS_OFF && loaded_q
		|=> prdata[3:0] == $past(stage_q) && stage_out_0 == stage_q[0] && stage_out_3 == stage_q[3])
		else $error("stage readout disagrees with the stages");

	loaded_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		apply && cur_mode == USR_LOAD && !loaded_q |=> loaded_q ##1 loaded_q)
		else $error("first load did not mark the stages as loaded");

	// serial entry reaches the end stages even before the first load
	right_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		apply && cur_mode == USR_SHR |=> stage_q[USR_STAGES-1] == $past(cur_cmd.right_in))
		else $error("right serial input did not reach stage three");

	left_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		apply && cur_mode == USR_SHL |=> stage_q[0] == $past(cur_cmd.left_in))
		else $error("left serial input did not reach stage zero");

	// the command sampled at the edge is the one recorded
	sampled_cmd_a: assert property (@(posedge pclk) disable iff (!presetn)
		apply |=> last_q == $past(cur_cmd))
		else $error("recorded command differs from the sampled one");

	last_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!apply |=> $stable(last_q))
		else $error("recorded command changed without an applied edge");

	// an empty queue leaves the stages alone
	empty_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		run && src_fifo && !fifo_out_valid && loaded_q |=> $stable(stage_q))
		else $error("stages moved while the queue was empty");

	// serial readout from either end stage
	right_serial_out_a: assert property (@(posedge pclk) disable iff (!presetn)
		loaded_q && apply && cur_mode == USR_SHR |=> stage_out_0 == $past(stage_q[1]))
		else $error("stage zero output missed the shifted bit");

	left_serial_out_a: assert property (@(posedge pclk) disable iff (!presetn)
		loaded_q && apply && cur_mode == USR_SHL |=> stage_out_3 == $past(stage_q[2]))
		else $error("stage three output missed the shifted bit");

	// first select is the high bit of the synced pin vector
	pin_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		run && !src_fifo |-> cur_mode == usr_mode_e'(pins_sync[USR_SYNC_W-1 -: 2]))
		else $error("pin selects decoded in the wrong order");

	loaded_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		loaded_q |=> loaded_q)
		else $error("loaded flag dropped without a reset");

	flag_only_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		!loaded_q && !(apply && cur_mode == USR_LOAD) |=> !loaded_q)
		else $error("loaded flag set without a parallel load");

	status_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && paddr == USR_STATUS_OFF
		|=> prdata[USR_ST_LOADED] == $past(loaded_q) && prdata[USR_ST_EMPTY] == $past(!fifo_out_valid))
		else $error("status flags disagree with the block state");

endmodule : usr_shift_top

`default_nettype wire

//--- rtl/usr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module usr_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// asynchronous inputs and their synchronised copy
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// meta_q feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : usr_sync

`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import usr_pkg::*;

	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [31:0] pwdata  = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	usr_cmd_s    cmd_req = '0;
	usr_cmd_s    pins;
	logic [3:0]  so;
	logic [31:0] rd;
	logic        er;
	logic [3:0]  st;
	int          cnt [4];
	int          err_count = 0;
	int          cmp_count = 0;
	logic [7:0]  tab [7] = '{8'h0A, 8'h50, 8'h40, 8'hA0, 8'h80, 8'hFF, 8'h35};

	always #10 pclk = ~pclk;

	usr_pin_model u_pins (.pclk(pclk), .cmd_req(cmd_req), .pins(pins));

	usr_shift_top u_dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .op_select_first(pins.sel_first), .op_select_second(pins.sel_second),
		.left_serial_in(pins.left_in), .right_serial_in(pins.right_in),
		.par_in_0(pins.par[0]), .par_in_1(pins.par[1]), .par_in_2(pins.par[2]), .par_in_3(pins.par[3]),
		.stage_out_0(so[0]), .stage_out_1(so[1]), .stage_out_2(so[2]), .stage_out_3(so[3])
	);

	task automatic report_and_stop;
		if (err_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer; returns read data and error flag
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (pready !== 1'b1) begin
			err_count++;
			report_and_stop();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// expected stages after one applied command
	function automatic logic [3:0] nxt(input logic [3:0] s, input logic [7:0] c);
		case (usr_mode_e'(c[7:6]))
			USR_LOAD: return c[3:0];
			USR_SHR:  return {c[4], s[3:1]};
			USR_SHL:  return {s[2:0], c[5]};
			default:  return s;
		endcase
	endfunction : nxt

	initial begin
		repeat (5000) @(posedge pclk);
		err_count++;
		report_and_stop();
	end

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(USR_CTRL_OFF, 1'b0, 32'h0);
		chk(rd, 32'h00000000);
		apb(USR_STATUS_OFF, 1'b0, 32'h0);
		chk(rd & 32'h00001F70, 32'h00000010);
		apb(12'h020, 1'b0, 32'h0);
		chk({31'h0, er}, 32'h00000001);
		apb(12'h018, 1'b1, 32'h3);
		chk({31'h0, er}, 32'h00000001);
		// queue source, running: one command per step, all modes
		apb(USR_CTRL_OFF, 1'b1, 32'h3);
		apb(USR_COUNT_OFF, 1'b1, 32'h0);
		st = 4'h0;
		cnt = '{0, 0, 0, 0};
		foreach (tab[i]) begin
			apb(USR_CMD_OFF, 1'b1, {24'h0, tab[i]});
			st = nxt(st, tab[i]);
			cnt[tab[i][7:6]]++;
			repeat (3) @(posedge pclk);
			chk({28'h0, so}, {28'h0, st});
			apb(USR_STATUS_OFF, 1'b0, 32'h0);
			chk(rd & 32'h0000007F, {25'h0, 3'b101, st});
			apb(USR_LAST_OFF, 1'b0, 32'h0);
			chk(rd, {24'h0, tab[i]});
		end
		apb(USR_COUNT_OFF, 1'b0, 32'h0);
		chk(rd, {8'(cnt[3]), 8'(cnt[2]), 8'(cnt[1]), 8'(cnt[0])});
		// fill the queue while stopped, then drain it
		apb(USR_CTRL_OFF, 1'b1, 32'h1);
		repeat (16) apb(USR_CMD_OFF, 1'b1, 32'hC0);
		apb(USR_STATUS_OFF, 1'b0, 32'h0);
		chk(rd & 32'h00001F30, 32'h00001020);
		apb(USR_CMD_OFF, 1'b1, 32'hC0);
		chk({31'h0, er}, 32'h00000001);
		apb(USR_CTRL_OFF, 1'b1, 32'h3);
		repeat (20) @(posedge pclk);
		apb(USR_STATUS_OFF, 1'b0, 32'h0);
		chk(rd & 32'h00001F3F, {27'h0, 1'b1, st});
		// pin source
		cmd_req <= usr_cmd_s'(8'h09);
		apb(USR_CTRL_OFF, 1'b1, 32'h2);
		repeat (6) @(posedge pclk);
		chk({28'h0, so}, 32'h00000009);
		cmd_req <= usr_cmd_s'(8'hCF);
		repeat (6) @(posedge pclk);
		chk({28'h0, so}, 32'h00000009);
		apb(USR_PINS_OFF, 1'b0, 32'h0);
		chk(rd, 32'h000000CF);
		apb(USR_CTRL_OFF, 1'b1, 32'h0);
		cmd_req <= usr_cmd_s'(8'h0A);
		repeat (6) @(posedge pclk);
		chk({28'h0, so}, 32'h00000009);
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire

//--- tb/usr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module usr_pin_model
	import usr_pkg::*;
(
	// clock
	input  wire logic     pclk,
	// command from the bench, pins toward the block
	input  wire usr_cmd_s cmd_req,
	output var usr_cmd_s  pins
);
	// pins move just after a rising edge and stay steady around the next one
	always @(posedge pclk) begin
		pins <= cmd_req;
	end
endmodule : usr_pin_model

`default_nettype wire
